// ---- eth_dma_map.vh ----
/*
 * register offsets, field positions, reset values and timing counts for
 * the dma bus-mode and transmit-poll front end.
 * assumes inclusion by bare name from the design files of this block.
 */
`ifndef ETH_DMA_MAP_VH
`define ETH_DMA_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_BUS_MODE 12'h000
`define OFS_TX_RECHECK 12'h004
`define OFS_TX_STATUS 12'h008

// ----------------------------------------------------------------------
// bus mode fields
// ----------------------------------------------------------------------
`define BM_TX_PRIO 27
`define BM_MIXED 26
`define BM_AAL 25
`define BM_X8 24
`define BM_SEP 23
`define BM_RX_BL_HI 22
`define BM_RX_BL_LO 17
`define BM_FIXED 16
`define BM_RATIO_HI 15
`define BM_RATIO_LO 14
`define BM_BL_HI 13
`define BM_BL_LO 8
`define BM_LONG_DESC 7
`define BM_GAP_HI 6
`define BM_GAP_LO 2
`define BM_ARB 1
`define BM_SRST 0
`define BM_RESET 32'h00020101
`define BM_WMASK 32'h0DFFFFFF

// ----------------------------------------------------------------------
// status fields and burst types
// ----------------------------------------------------------------------
`define ST_TX_UNAVAIL 2
`define ST_TX_SUSP 0
`define HB_SINGLE 3'h0
`define HB_INCR 3'h1
`define HB_INCR4 3'h3
`define HB_INCR8 3'h5
`define HB_INCR16 3'h7

// ----------------------------------------------------------------------
// timing: soft reset held per domain, in ns, and cycles at 100 mhz
// ----------------------------------------------------------------------
`define SRST_HOLD_NS 40
`define CLK_PERIOD_NS 10
`define SRST_HOLD_CYC ((`SRST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- eth_dma_sync2.v ----
/*
 * two flip-flop level synchroniser.
 * assumes an asynchronous level in and one receiving clock.
 */
`timescale 1ns/10ps
module eth_dma_sync2 (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_en,
	input wire i_async,
	output wire o_sync
);
	reg meta_q;
	reg sync_q;
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else if (i_en) begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end
	assign o_sync = sync_q;
endmodule

// ---- eth_dma_arbiter.v ----
/*
 * rx/tx arbiter for the host bus master: fixed priority or weighted
 * round robin.
 * assumes requests stay up until granted; grants are combinational and stay up for as long as they are given.
 */
`timescale 1ns/10ps
module eth_dma_arbiter (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_en,
	input wire i_fixed_prio,
	input wire i_tx_prio,
	input wire [1:0] i_ratio,
	input wire i_tx_req,
	input wire i_rx_req,
	output reg o_tx_gnt,
	output reg o_rx_gnt
);
	// one bit wider than the ratio so the 4:1 count can reach its limit
	reg [2:0] credit_q;
	reg fav_tx;
	reg fav_gnt;
	reg oth_gnt;
	reg fav_req;
	reg oth_req;
	always @* begin
		fav_tx = i_tx_prio;
		fav_req = fav_tx ? i_tx_req : i_rx_req;
		oth_req = fav_tx ? i_rx_req : i_tx_req;
		if (i_fixed_prio) begin
			fav_gnt = fav_req;
		end else begin
			// favoured side gets ratio+1 grants per one of the other
			fav_gnt = fav_req & (!oth_req || credit_q <= {1'b0, i_ratio});
		end
		oth_gnt = oth_req & !fav_gnt;
		o_tx_gnt = fav_tx ? fav_gnt : oth_gnt;
		o_rx_gnt = fav_tx ? oth_gnt : fav_gnt;
	end
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			credit_q <= 3'h0;
		end else if (i_en) begin
			if (oth_gnt || i_fixed_prio)
				credit_q <= 3'h0;
			else if (fav_gnt && oth_req)
				credit_q <= credit_q + 3'h1;
		end
	end
endmodule

// ---- eth_dma_bus_mode.v ----
/*
 * bus mode configuration and transmit poll demand front end of an
 * ethernet dma, with an axi4-lite register slave.
 * assumes the tx engine reports descriptor fetches and ownership, and
 * that the phy clock domain signals its own reset release by a level.
 */
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "eth_dma_map.vh"
module eth_dma_bus_mode #(
	parameter ADDR_W = 12
) (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_clk_en,
	input wire [ADDR_W-1:0] i_awaddr,
	input wire i_awvalid,
	output wire o_awready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output wire o_wready,
	output wire [1:0] o_bresp,
	output wire o_bvalid,
	input wire i_bready,
	input wire [ADDR_W-1:0] i_araddr,
	input wire i_arvalid,
	output wire o_arready,
	output wire [31:0] o_rdata,
	output wire [1:0] o_rresp,
	output wire o_rvalid,
	input wire i_rready,
	input wire i_phy_rst_done,
	output wire o_dma_rst,
	input wire i_tx_req,
	input wire i_rx_req,
	output wire o_tx_gnt,
	output wire o_rx_gnt,
	input wire i_tx_burst_start,
	output reg [7:0] o_tx_beats,
	output reg [2:0] o_tx_htrans_burst,
	input wire i_rx_burst_start,
	output reg [7:0] o_rx_beats,
	output reg [2:0] o_rx_htrans_burst,
	output reg [5:0] o_desc_bytes,
	output reg [6:0] o_desc_gap_bytes,
	output wire o_fetch_req,
	input wire i_fetch_start,
	input wire i_fetch_done,
	input wire i_fetch_host_owned,
	input wire i_tx_underflow,
	output wire o_tx_suspended
);
	// ------------------------------------------------------------------
	// registers and soft reset
	// ------------------------------------------------------------------
	reg [31:0] bus_mode_q;
	reg poll_pend_q;
	reg tx_susp_q;
	reg tx_unavail_q;
	reg [3:0] srst_cnt_q;
	reg srst_busy_q;
	wire phy_done_s;
	wire soft_rst;
	wire en;

	assign en = i_clk_en;
	assign soft_rst = srst_busy_q;
	assign o_dma_rst = soft_rst;

	// phy-side release comes from another clock domain
	eth_dma_sync2 u_phy_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_en(en),
		.i_async(i_phy_rst_done),
		.o_sync(phy_done_s)
	);

	// ------------------------------------------------------------------
	// axi4-lite slave: one write and one read in flight
	// ------------------------------------------------------------------
	reg aw_have_q;
	reg w_have_q;
	reg [ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	wire wr_go;
	wire rd_go;
	wire [31:0] wmask;
	wire wr_bm;
	wire wr_poll;

	assign o_awready = en && !aw_have_q && !bvalid_q;
	assign o_wready = en && !w_have_q && !bvalid_q;
	assign wr_go = en && aw_have_q && w_have_q && !bvalid_q;
	assign o_arready = en && !rvalid_q;
	assign rd_go = i_arvalid && o_arready;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// writes during an active soft reset are dropped
	assign wr_bm = wr_go && awaddr_q[11:0] == `OFS_BUS_MODE && !soft_rst;
	assign wr_poll = wr_go && awaddr_q[11:0] == `OFS_TX_RECHECK &&
		!soft_rst && wstrb_q != 4'h0;

	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= {ADDR_W{1'b0}};
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else if (en) begin
			if (i_awvalid && o_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				case (awaddr_q[11:0])
				`OFS_BUS_MODE: bresp_q <= 2'h0;
				`OFS_TX_RECHECK: bresp_q <= 2'h0;
				`OFS_TX_STATUS: bresp_q <= 2'h0;
				default: bresp_q <= 2'h2;
				endcase
			end else if (bvalid_q && i_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end else if (en) begin
			if (rd_go) begin
				rvalid_q <= 1'b1;
				rresp_q <= 2'h0;
				case (i_araddr[11:0])
				`OFS_BUS_MODE: rdata_q <= bus_mode_q & ~32'hF0000000;
				`OFS_TX_RECHECK: rdata_q <= 32'h00000000;
				`OFS_TX_STATUS: begin
					rdata_q <= 32'h00000000;
					rdata_q[`ST_TX_UNAVAIL] <= tx_unavail_q;
					rdata_q[`ST_TX_SUSP] <= tx_susp_q;
				end
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= 2'h2;
				end
				endcase
			end else if (rvalid_q && i_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// bus mode register and soft reset sequencing
	// ------------------------------------------------------------------
	always @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			bus_mode_q <= `BM_RESET;
			srst_busy_q <= 1'b1;
			srst_cnt_q <= 4'h0;
		end else if (en) begin
			if (srst_busy_q) begin
				bus_mode_q <= `BM_RESET;
				if (srst_cnt_q != `SRST_HOLD_CYC)
					srst_cnt_q <= srst_cnt_q + 4'h1;
				else if (phy_done_s) begin
					srst_busy_q <= 1'b0;
					bus_mode_q[`BM_SRST] <= 1'b0;
				end
			end else if (wr_bm) begin
				// bits 31:28 and the aligned-beats bit never store
				bus_mode_q <= (bus_mode_q & ~(wmask & `BM_WMASK)) |
					(wdata_q & wmask & `BM_WMASK);
				if (wstrb_q[0] && wdata_q[`BM_SRST]) begin
					srst_busy_q <= 1'b1;
					srst_cnt_q <= 4'h0;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// burst length and type selection
	// ------------------------------------------------------------------
	wire x8 = bus_mode_q[`BM_X8];
	wire fixed_b = bus_mode_q[`BM_FIXED];
	wire mixed_b = bus_mode_q[`BM_MIXED];
	wire [5:0] tx_bl = bus_mode_q[`BM_BL_HI:`BM_BL_LO];
	wire [5:0] rx_bl = bus_mode_q[`BM_SEP] ?
		bus_mode_q[`BM_RX_BL_HI:`BM_RX_BL_LO] : tx_bl;
	wire [8:0] tx_beats = x8 ? {tx_bl, 3'h0} : {3'h0, tx_bl};
	wire [8:0] rx_beats = x8 ? {rx_bl, 3'h0} : {3'h0, rx_bl};

	function [2:0] burst_kind;
		input [8:0] beats;
		input fx;
		input mx;
		begin
			if (!fx)
				burst_kind = beats == 9'h001 ? `HB_SINGLE : `HB_INCR;
			else if (mx && beats > 9'h010)
				burst_kind = `HB_INCR;
			else if (beats >= 9'h010)
				burst_kind = `HB_INCR16;
			else if (beats >= 9'h008)
				burst_kind = `HB_INCR8;
			else if (beats >= 9'h004)
				burst_kind = `HB_INCR4;
			else
				burst_kind = `HB_SINGLE;
		end
	endfunction

	// beats and burst type latched at each burst start so a mid-burst write cannot alter them unless it starts a soft reset, which clears them
	always @(posedge i_clk_sys) begin
		if (!i_reset_n || (en && soft_rst)) begin
			o_tx_beats <= 8'h00;
			o_tx_htrans_burst <= `HB_SINGLE;
			o_rx_beats <= 8'h00;
			o_rx_htrans_burst <= `HB_SINGLE;
			o_desc_bytes <= 6'h10;
			o_desc_gap_bytes <= 7'h00;
		end else if (en) begin
			if (i_tx_burst_start) begin
				o_tx_beats <= tx_beats[7:0];
				o_tx_htrans_burst <= burst_kind(tx_beats, fixed_b, mixed_b);
			end
			if (i_rx_burst_start) begin
				o_rx_beats <= rx_beats[7:0];
				o_rx_htrans_burst <= burst_kind(rx_beats, fixed_b, mixed_b);
			end
			o_desc_bytes <= bus_mode_q[`BM_LONG_DESC] ? 6'h20 : 6'h10;
			o_desc_gap_bytes <= {bus_mode_q[`BM_GAP_HI:`BM_GAP_LO], 2'h0};
		end
	end

	// ------------------------------------------------------------------
	// arbitration
	// ------------------------------------------------------------------
	eth_dma_arbiter u_arb (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n && !(en && soft_rst)),
		.i_en(en),
		.i_fixed_prio(bus_mode_q[`BM_ARB]),
		.i_tx_prio(bus_mode_q[`BM_TX_PRIO]),
		.i_ratio(bus_mode_q[`BM_RATIO_HI:`BM_RATIO_LO]),
		.i_tx_req(i_tx_req && !soft_rst),
		.i_rx_req(i_rx_req && !soft_rst),
		.o_tx_gnt(o_tx_gnt),
		.o_rx_gnt(o_rx_gnt)
	);

	// ------------------------------------------------------------------
	// transmit poll demand and suspend
	// ------------------------------------------------------------------
	assign o_fetch_req = poll_pend_q;
	assign o_tx_suspended = tx_susp_q;

	always @(posedge i_clk_sys) begin
		if (!i_reset_n || (en && soft_rst)) begin
			poll_pend_q <= 1'b0;
			tx_susp_q <= 1'b1;
			tx_unavail_q <= 1'b0;
		end else if (en) begin
			// a new write wins over the clear in the same cycle
			if (wr_poll)
				poll_pend_q <= 1'b1;
			else if (i_fetch_start)
				poll_pend_q <= 1'b0;
			if (i_tx_underflow)
				tx_susp_q <= 1'b1;
			else if (i_fetch_done)
				tx_susp_q <= i_fetch_host_owned;
			if (i_fetch_done && i_fetch_host_owned)
				tx_unavail_q <= 1'b1;
			else if (wr_go && awaddr_q[11:0] == `OFS_TX_STATUS &&
				wstrb_q[0] && wdata_q[`ST_TX_UNAVAIL])
				tx_unavail_q <= 1'b0;
		end
	end
endmodule

// ---- eth_dma_bus_mode_props.sv ----
/* port checks for the dma bus mode and poll demand block.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
module eth_dma_bus_mode_props (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_clk_en,
	input wire i_awvalid,
	input wire i_wvalid,
	input wire i_phy_rst_done,
	input wire o_dma_rst,
	input wire i_tx_req,
	input wire i_rx_req,
	input wire o_tx_gnt,
	input wire o_rx_gnt,
	input wire o_fetch_req,
	input wire i_fetch_start,
	input wire i_fetch_done,
	input wire i_fetch_host_owned,
	input wire i_tx_underflow,
	input wire o_tx_suspended
);
// ----------------------------------------------------------------
// properties
// ----------------------------------------------------------------
default clocking cb @(posedge i_clk_sys); endclocking
default disable iff (!i_reset_n);
property p_gnt_excl;
	!(o_tx_gnt && o_rx_gnt);
endproperty
a_gnt_excl: assert property (p_gnt_excl) else $error("two grants");
property p_gnt_req;
	(o_tx_gnt |-> i_tx_req) and (o_rx_gnt |-> i_rx_req);
endproperty
a_gnt_req: assert property (p_gnt_req) else $error("grant no req");
property p_srst_min;
	$rose(o_dma_rst) |-> o_dma_rst [*4];
endproperty
a_srst_min: assert property (p_srst_min) else $error("srst short");
// the phy level passes a two-stage synchroniser, so wait three cycles
property p_srst_phy;
	(!i_phy_rst_done) [*3] ##0 o_dma_rst |=> o_dma_rst;
endproperty
a_srst_phy: assert property (p_srst_phy) else $error("srst early");
property p_uflow;
	i_clk_en && i_tx_underflow |=> o_tx_suspended;
endproperty
a_uflow: assert property (p_uflow) else $error("no suspend");
property p_resume;
	i_clk_en && i_fetch_done && !i_fetch_host_owned && !i_tx_underflow
		|=> !o_tx_suspended;
endproperty
a_resume: assert property (p_resume) else $error("no resume");
property p_fetch_hold;
	i_clk_en && o_fetch_req && !i_fetch_start && !o_dma_rst |=> o_fetch_req;
endproperty
a_fetch_hold: assert property (p_fetch_hold) else $error("poll lost");
property p_fetch_clr;
	i_clk_en && o_fetch_req && i_fetch_start && !i_awvalid && !i_wvalid
		|=> !o_fetch_req;
endproperty
a_fetch_clr: assert property (p_fetch_clr) else $error("poll stuck");
c_wrr: cover property (o_rx_gnt && i_tx_req);
c_owned: cover property (i_fetch_done && i_fetch_host_owned);
c_srst: cover property ($fell(o_dma_rst));
endmodule
bind eth_dma_bus_mode eth_dma_bus_mode_props eth_dma_bus_mode_props_i (.*);

// ---- eth_dma_host_model.sv ----
/* far side model: descriptor refetch from host memory for the tx engine.
 * assumes the block's poll request level and the shared system clock.
 */
`timescale 1ns/10ps
module eth_dma_host_model (
	input wire i_clk_sys,
	input wire i_reset_n,
	input wire i_fetch_req,
	input wire i_host_owned,
	input wire i_slow,
	output reg o_fetch_start,
	output reg o_fetch_done,
	output wire o_fetch_host_owned
);
// ----------------------------------------------------------------
// fetch sequencing
// ----------------------------------------------------------------
reg [3:0] cnt_q;
reg own_q;
// ownership means nothing outside the done pulse, so it is inverted there
assign o_fetch_host_owned = o_fetch_done ? own_q : ~own_q;
always @(posedge i_clk_sys) begin
	o_fetch_start <= 1'h0;
	o_fetch_done <= 1'h0;
	if (!i_reset_n) begin
		cnt_q <= 4'h0;
		own_q <= 1'h0;
	end else if (cnt_q != 4'h0) begin
		cnt_q <= cnt_q - 4'h1;
		if (cnt_q == 4'h1) begin
			o_fetch_done <= 1'h1;
			own_q <= i_host_owned;
		end
	end else if (i_fetch_req) begin
		o_fetch_start <= 1'h1;
		cnt_q <= i_slow ? 4'h8 : 4'h1;
	end
end
endmodule

// ---- testbench.sv ----
/* self-checking bench for the dma bus mode and poll demand block.
 * assumes the block, its checker and the host model are compiled first.
 */
`timescale 1ns/10ps
module testbench;
logic i_clk_sys = 1'h0, i_reset_n = 1'h0, i_clk_en = 1'h1;
logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
logic i_arvalid = 1'h0, i_rready = 1'h0, i_phy_rst_done = 1'h0;
logic i_tx_req = 1'h0, i_rx_req = 1'h0, i_tx_underflow = 1'h0;
logic i_tx_burst_start = 1'h0, i_rx_burst_start = 1'h0;
logic host_owned = 1'h0, slow = 1'h0;
logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
logic [31:0] i_wdata = 32'h0, rv;
logic [3:0] i_wstrb = 4'hF;
wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dma_rst;
wire o_tx_gnt, o_rx_gnt, o_fetch_req, o_tx_suspended;
wire i_fetch_start, i_fetch_done, i_fetch_host_owned;
wire [1:0] o_bresp, o_rresp;
wire [31:0] o_rdata;
wire [7:0] o_tx_beats, o_rx_beats;
wire [2:0] o_tx_htrans_burst, o_rx_htrans_burst;
wire [5:0] o_desc_bytes;
wire [6:0] o_desc_gap_bytes;
int errors = 0, n_checks = 0, cyc = 0;
eth_dma_bus_mode eth_dma_bus_mode_i (.*);
eth_dma_host_model eth_dma_host_model_i (.i_clk_sys, .i_reset_n,
	.i_fetch_req(o_fetch_req), .i_host_owned(host_owned), .i_slow(slow),
	.o_fetch_start(i_fetch_start), .o_fetch_done(i_fetch_done),
	.o_fetch_host_owned(i_fetch_host_owned));
always #5 i_clk_sys = ~i_clk_sys;
always @(posedge i_clk_sys) begin
	cyc++;
	if (cyc == 20000) begin
		errors++;
		end_sim();
	end
end
// ----------------------------------------------------------------
// shared tasks; idle point is the falling edge
// ----------------------------------------------------------------
task automatic end_sim();
	$display("checks %0d errors %0d", n_checks, errors);
	if (errors == 0 && n_checks > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
task automatic chk(input string nm, input logic [31:0] s, e);
	n_checks++;
	if (s !== e) begin
		errors++;
		$display("MISMATCH %s expected %h seen %h", nm, e, s);
	end
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d,
	input logic [1:0] er);
	logic ta, tw, tb;
	int n;
	tb = 1'h0;
	n = 0;
	@(posedge i_clk_sys);
	i_awaddr <= a;
	i_wdata <= d;
	{i_awvalid, i_wvalid, i_bready} <= 3'h7;
	while (!tb && n < 50) begin
		@(negedge i_clk_sys);
		ta = i_awvalid && o_awready;
		tw = i_wvalid && o_wready;
		tb = o_bvalid;
		if (tb) chk("bresp", o_bresp, er);
		@(posedge i_clk_sys);
		if (ta) i_awvalid <= 1'h0;
		if (tw) i_wvalid <= 1'h0;
		n++;
	end
	i_bready <= 1'h0;
	chk("bvalid", tb, 1'h1);
	@(negedge i_clk_sys);
endtask
task automatic rd(input logic [11:0] a, input logic [1:0] er);
	logic ta, tr;
	int n;
	tr = 1'h0;
	n = 0;
	@(posedge i_clk_sys);
	i_araddr <= a;
	{i_arvalid, i_rready} <= 2'h3;
	while (!tr && n < 50) begin
		@(negedge i_clk_sys);
		ta = i_arvalid && o_arready;
		tr = o_rvalid;
		rv = o_rdata;
		if (tr) chk("rresp", o_rresp, er);
		@(posedge i_clk_sys);
		if (ta) i_arvalid <= 1'h0;
		n++;
	end
	i_rready <= 1'h0;
	chk("rvalid", tr, 1'h1);
	@(negedge i_clk_sys);
endtask
task automatic rc(input logic [11:0] a, input logic [31:0] e);
	rd(a, 2'h0);
	chk("rdata", rv, e);
endtask
task automatic wait_srst();
	int n;
	n = 0;
	rv = 32'h1;
	while (rv[0] && n < 40) begin
		rd(12'h000, 2'h0);
		n++;
	end
	chk("srst_done", rv[0], 1'h0);
endtask
// ----------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------
task automatic t_phy();
	repeat (20) @(negedge i_clk_sys);
	chk("dma_rst", o_dma_rst, 1'h1);
	rc(12'h000, 32'h00020101);
	@(posedge i_clk_sys);
	i_phy_rst_done <= 1'h1;
	wait_srst();
	rc(12'h000, 32'h00020100);
endtask
task automatic t_regs();
	wr(12'h000, 32'hFDA1D0FE, 2'h0);
	rc(12'h000, 32'h0DA1D0FE);
	chk("desc", o_desc_bytes, 6'h20);
	chk("gap", o_desc_gap_bytes, 7'h7C);
	rd(12'h00C, 2'h2);
	chk("unmapped", rv, 32'h0);
	wr(12'h010, 32'h0, 2'h2);
	wr(12'h000, 32'h1, 2'h0);
	chk("dma_rst", o_dma_rst, 1'h1);
	wait_srst();
	rc(12'h000, 32'h00020100);
	chk("desc", o_desc_bytes, 6'h10);
endtask
task automatic t_burst();
	logic [31:0] bm [4] = '{32'h00080800, 32'h00010100, 32'h05890200,
		32'h00910400};
	logic [21:0] ex [4] = '{{8'h08, 3'h1, 8'h08, 3'h1},
		{8'h01, 3'h0, 8'h01, 3'h0}, {8'h10, 3'h7, 8'h20, 3'h1},
		{8'h04, 3'h3, 8'h08, 3'h5}};
	for (int i = 0; i < 4; i++) begin
		wr(12'h000, bm[i] & 32'hFFFFC0FF, 2'h0);
		wr(12'h000, bm[i], 2'h0);
		@(posedge i_clk_sys);
		{i_tx_burst_start, i_rx_burst_start} <= 2'h3;
		@(posedge i_clk_sys);
		{i_tx_burst_start, i_rx_burst_start} <= 2'h0;
		@(negedge i_clk_sys);
		chk("tx", {o_tx_beats, o_tx_htrans_burst}, ex[i][21:11]);
		chk("rx", {o_rx_beats, o_rx_htrans_burst}, ex[i][10:0]);
	end
endtask
task automatic t_arb();
	int nt, nr, n, f;
	for (int c = 0; c < 16; c++) begin
		wr(12'h000, {4'h0, c[2], 11'h000, c[1:0], 6'h01, 6'h00, c[3], 1'h0},
			2'h0);
		n = 2 * (c[1:0] + 2);
		nt = 0;
		nr = 0;
		@(posedge i_clk_sys);
		{i_tx_req, i_rx_req} <= 2'h3;
		for (int k = 0; k < n + n / 2; k++) begin
			@(negedge i_clk_sys);
			if (k >= n / 2) begin
				nt += o_tx_gnt;
				nr += o_rx_gnt;
			end
		end
		f = c[3] ? n : n - 2;
		chk("tx_gnt", nt, c[2] ? f : n - f);
		chk("rx_gnt", nr, c[2] ? n - f : f);
		@(posedge i_clk_sys);
		{i_tx_req, i_rx_req} <= 2'h0;
		@(negedge i_clk_sys);
	end
endtask
task automatic t_poll();
	for (int s = 0; s < 2; s++) begin
		slow = s[0];
		@(posedge i_clk_sys);
		i_tx_underflow <= 1'h1;
		@(posedge i_clk_sys);
		i_tx_underflow <= 1'h0;
		@(negedge i_clk_sys);
		chk("susp", o_tx_suspended, 1'h1);
		host_owned = 1'h1;
		wr(12'h004, 32'h0, 2'h0);
		repeat (12) @(negedge i_clk_sys);
		chk("susp", o_tx_suspended, 1'h1);
		rc(12'h008, 32'h5);
		wr(12'h008, 32'h4, 2'h0);
		rc(12'h008, 32'h1);
		host_owned = 1'h0;
		wr(12'h004, 32'hFFFFFFFF, 2'h0);
		repeat (12) @(negedge i_clk_sys);
		chk("susp", o_tx_suspended, 1'h0);
		chk("poll", o_fetch_req, 1'h0);
		rc(12'h004, 32'h0);
		rc(12'h008, 32'h0);
	end
endtask
initial begin
	repeat (5) @(posedge i_clk_sys);
	i_reset_n <= 1'h1;
	@(negedge i_clk_sys);
	t_phy();
	t_regs();
	t_burst();
	t_arb();
	t_poll();
	end_sim();
end
endmodule
